// file: verilog/frcs_map.vh
// Constants for the floppy read command sequencer.
// Assumes inclusion by bare name from the sequencer.
//
// Summary of operation
// - Skip flag passes over deleted sectors on read
// - Read deleted with skip touches only deleted
// - Skip clear reads every sector regardless of mark
// - Step pulses spaced 0.5 to 8 ms
// - Four status bytes held, first three read in result
// - Write gate timing shifts write enable lead
// - Seven result bytes returned in order; an invalid opcode returns one
// - Sector length is 128 shifted by size
// - Slot index is first sector, then increments
`ifndef FRCS_MAP_VH
`define FRCS_MAP_VH
// ----------------------------------------------------------------
// Opcodes and fields
// ----------------------------------------------------------------
`define FRCS_OP_MASK 8'h1F
`define FRCS_OP_READ 8'h06
`define FRCS_OP_READ_DEL 8'h0C
`define FRCS_BIT_MULTI 7
`define FRCS_BIT_DENS 6
`define FRCS_BIT_SKIP 5
`define FRCS_BIT_HEAD 2
`define FRCS_CMD_BYTES 4'h9
`define FRCS_RES_BYTES 3'h7
`define FRCS_SIZE_MAX 8'h07
`define FRCS_BASE_LEN 15'h0080
// ----------------------------------------------------------------
// Status bits
// ----------------------------------------------------------------
`define FRCS_SB0_ABNORMAL 8'h40
`define FRCS_SB0_INVALID 8'h80
`define FRCS_SB1_END_CYL 8'h80
`define FRCS_SB2_CTRL_MARK 8'h40
`define FRCS_SB3_TWO_SIDE 8'h08
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FRCS_CLK_MHZ 100
`define FRCS_STEP_UNIT_US 500
`define FRCS_STEP_UNIT_CYC (`FRCS_STEP_UNIT_US * `FRCS_CLK_MHZ)
`define FRCS_WG_UNIT_CYC 8'h64
`endif

// file: verilog/frcs_fifo.v
// Synchronous FIFO for sector data between the drive and the system.
// Assumes one clock domain and both sides handshaking on valid/ready.
`timescale 1ns/1ps
module frcs_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire mclk,
	input wire rst,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0] wptr_reg;
	reg [AW-1:0] rptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;
	// ----------------------------------------------------------------
	// Handshake
	// ----------------------------------------------------------------
	// Full and empty come from the count, so depth need not be a power of two
	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem_reg[rptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Pointer and storage update
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			wptr_reg <= {AW{1'b0}};
			rptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wptr_reg <= (wptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= (rptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
	// Data array carries no reset; its contents are qualified by the count
	always @(posedge mclk) begin
		if (push) begin
			mem_reg[wptr_reg] <= in_data;
		end
	end
endmodule // frcs_fifo

// file: verilog/frcs_seq.v
// Command, execution and result sequencer for read data and read deleted data.
// Assumes the host port and drive sector stream are on mclk; step request
// and write request inputs come from pins and are synchronised here.
`timescale 1ns/1ps
`include "frcs_map.vh"
module frcs_seq #(
	parameter STEP_UNIT_CYC = `FRCS_STEP_UNIT_CYC,
	parameter FIFO_DEPTH = 8
) (
	input wire mclk,
	input wire rst,
	input wire [7:0] cmd_data,
	input wire cmd_wr,
	output reg cmd_ready,
	output reg [7:0] res_data,
	output reg res_valid,
	input wire res_rd,
	output reg busy,
	input wire [3:0] step_interval,
	input wire [3:0] write_gate_timing,
	input wire step_req,
	output reg step_pulse,
	input wire wr_req,
	output reg write_enable,
	input wire [7:0] sec_data,
	input wire sec_valid,
	input wire sec_start,
	input wire sec_deleted,
	input wire sec_last,
	input wire sec_error,
	output reg sec_ready,
	output reg [7:0] sys_data,
	output reg sys_valid,
	input wire sys_ready,
	output reg [7:0] req_sector,
	output reg [15:0] sector_length,
	output reg density_select,
	output reg head_select,
	output reg [1:0] drive_select,
	input wire drive_two_side,
	input wire drive_ready
);
	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam S_CMD = 4'b0001;
	localparam S_EXEC = 4'b0010;
	localparam S_RES = 4'b0100;
	localparam S_IDLE = 4'b1000;
	reg [3:0] state_reg;
	reg [3:0] cnt_reg;
	reg [7:0] cmd_reg [0:8];
	reg [7:0] cyl_reg, head_reg, sec_reg, size_reg;
	reg [7:0] status_byte_zero, status_byte_one, status_byte_two, status_byte_three;
	reg skip_reg;
	reg want_del_reg;
	reg drop_reg;
	wire [7:0] op_byte;
	wire multi_track_flag;
	wire skip_deleted_flag;
	wire fifo_in_ready, fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire fifo_push;
	assign op_byte = cmd_reg[0];
	assign multi_track_flag = op_byte[`FRCS_BIT_MULTI];
	assign skip_deleted_flag = op_byte[`FRCS_BIT_SKIP];
	// Decoding reused for the opcode check and the mark filter
	function is_del_cmd;
		input [7:0] b;
		begin
			is_del_cmd = ((b & `FRCS_OP_MASK) == `FRCS_OP_READ_DEL);
		end
	endfunction
	function is_rd_cmd;
		input [7:0] b;
		begin
			is_rd_cmd = ((b & `FRCS_OP_MASK) == `FRCS_OP_READ) || is_del_cmd(b);
		end
	endfunction
	// ----------------------------------------------------------------
	// Data path FIFO
	// ----------------------------------------------------------------
	// Dropped sectors still drain the drive stream but never reach the FIFO
	assign fifo_push = sec_valid && sec_ready && !drop_reg;
	frcs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_data(sec_data),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(sys_ready && sys_valid)
	);
	// Registered system side; the FIFO head is mirrored each cycle
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			sys_data <= 8'h00;
			sys_valid <= 1'b0;
			sec_ready <= 1'b0;
		end else begin
			sys_data <= fifo_out_data;
			sys_valid <= fifo_out_valid && !(sys_valid && sys_ready);
			// Ready rests one cycle after each byte so a full FIFO is seen in time
			sec_ready <= (state_reg == S_EXEC) && (fifo_in_ready || drop_reg) && !(sec_valid && sec_ready);
		end
	end
	// ----------------------------------------------------------------
	// Main sequencer
	// ----------------------------------------------------------------
	// With skip set, a mark that fails the filter drops the whole sector
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= S_IDLE;
			cnt_reg <= 4'h0;
			cmd_ready <= 1'b0;
			res_valid <= 1'b0;
			res_data <= 8'h00;
			busy <= 1'b0;
			cyl_reg <= 8'h00;
			head_reg <= 8'h00;
			sec_reg <= 8'h00;
			size_reg <= 8'h00;
			skip_reg <= 1'b0;
			want_del_reg <= 1'b0;
			drop_reg <= 1'b0;
			status_byte_zero <= 8'h00;
			status_byte_one <= 8'h00;
			status_byte_two <= 8'h00;
			status_byte_three <= 8'h00;
			req_sector <= 8'h00;
			sector_length <= 16'h0000;
			density_select <= 1'b0;
			head_select <= 1'b0;
			drive_select <= 2'b00;
		end else begin
			status_byte_three <= (drive_two_side ? `FRCS_SB3_TWO_SIDE : 8'h00) | {5'h00, head_select, drive_select};
			case (state_reg)
			S_IDLE: begin
				cmd_ready <= 1'b1;
				cnt_reg <= 4'h0;
				state_reg <= S_CMD;
			end
			S_CMD: begin
				if (cmd_wr && cmd_ready) begin
					cmd_reg[cnt_reg] <= cmd_data;
					if (cnt_reg == 4'h0 && !is_rd_cmd(cmd_data)) begin
						// Unknown opcode: one invalid status byte, no parameters
						status_byte_zero <= `FRCS_SB0_INVALID;
						cmd_ready <= 1'b0;
						cnt_reg <= 4'h6;
						res_valid <= 1'b0;
						state_reg <= S_RES;
					end else if (cnt_reg == `FRCS_CMD_BYTES - 4'h1) begin
						cmd_ready <= 1'b0;
						busy <= 1'b1;
						cnt_reg <= 4'h0;
						state_reg <= S_EXEC;
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
					end
				end
			end
			S_EXEC: begin
				if (cnt_reg == 4'h0) begin
					// Latch parameters once the ninth byte is in
					head_select <= cmd_reg[1][`FRCS_BIT_HEAD];
					drive_select <= cmd_reg[1][1:0];
					cyl_reg <= cmd_reg[2];
					head_reg <= cmd_reg[3];
					sec_reg <= cmd_reg[4];
					req_sector <= cmd_reg[4];
					size_reg <= cmd_reg[5];
					sector_length <= {1'b0, `FRCS_BASE_LEN << cmd_reg[5][2:0]};
					density_select <= op_byte[`FRCS_BIT_DENS];
					skip_reg <= skip_deleted_flag;
					want_del_reg <= is_del_cmd(op_byte);
					status_byte_zero <= {5'h00, cmd_reg[1][2:0]};
					status_byte_one <= 8'h00;
					status_byte_two <= 8'h00;
					cnt_reg <= 4'h1;
					if (cmd_reg[5] > `FRCS_SIZE_MAX || !drive_ready) begin
						status_byte_zero <= `FRCS_SB0_ABNORMAL | {5'h00, cmd_reg[1][2:0]};
						cnt_reg <= 4'h0;
						state_reg <= S_RES;
					end
				end else begin
					if (sec_start) begin
						// Skip set: wrong mark dropped silently; skip clear: all read
						drop_reg <= skip_reg && (sec_deleted != want_del_reg);
						if (!skip_reg && (sec_deleted != want_del_reg)) begin
							status_byte_two <= status_byte_two | `FRCS_SB2_CTRL_MARK;
						end
					end
					if (sec_error) begin
						status_byte_zero <= status_byte_zero | `FRCS_SB0_ABNORMAL;
						state_reg <= S_RES;
						cnt_reg <= 4'h0;
					end else if (sec_last && sec_valid && sec_ready) begin
						drop_reg <= 1'b0;
						if (sec_reg == cmd_reg[6]) begin
							if (multi_track_flag && !head_reg[0]) begin
								head_reg <= 8'h01;
								head_select <= 1'b1;
								sec_reg <= 8'h01;
								req_sector <= 8'h01;
							end else begin
								status_byte_zero <= status_byte_zero | `FRCS_SB0_ABNORMAL;
								status_byte_one <= `FRCS_SB1_END_CYL;
								cyl_reg <= cyl_reg + 8'h01;
								sec_reg <= 8'h01;
								state_reg <= S_RES;
								cnt_reg <= 4'h0;
							end
						end else begin
							sec_reg <= sec_reg + 8'h01;
							req_sector <= sec_reg + 8'h01;
						end
					end
				end
			end
			S_RES: begin
				busy <= 1'b1;
				// Seven bytes; the invalid path enters at the last slot
				if (!res_valid || res_rd) begin
					if (res_valid && cnt_reg == {1'b0, `FRCS_RES_BYTES}) begin
						res_valid <= 1'b0;
						busy <= 1'b0;
						state_reg <= S_IDLE;
					end else begin
						res_valid <= 1'b1;
						cnt_reg <= (cnt_reg == 4'h6) ? {1'b0, `FRCS_RES_BYTES} : cnt_reg + 4'h1;
						case (cnt_reg)
						4'h0: res_data <= status_byte_zero;
						4'h1: res_data <= status_byte_one;
						4'h2: res_data <= status_byte_two;
						4'h3: res_data <= cyl_reg;
						4'h4: res_data <= head_reg;
						4'h5: res_data <= sec_reg;
						4'h6: res_data <= (status_byte_zero == `FRCS_SB0_INVALID) ? status_byte_zero : size_reg;
						default: res_data <= 8'h00;
						endcase
					end
				end
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Step and write gate timing
	// ----------------------------------------------------------------
	// Three-stage synchronisers; a change counts when stages two and three agree
	reg [2:0] step_sync_reg, wr_sync_reg;
	reg step_lvl_reg, wr_lvl_reg;
	reg [16:0] unit_cnt_reg;
	reg unit_tick_reg;
	reg [4:0] step_gap_reg;
	reg [7:0] wg_cnt_reg;
	reg [3:0] wg_units_reg;
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			step_sync_reg <= 3'b000;
			wr_sync_reg <= 3'b000;
			step_lvl_reg <= 1'b0;
			wr_lvl_reg <= 1'b0;
			unit_cnt_reg <= 17'h00000;
			unit_tick_reg <= 1'b0;
			step_gap_reg <= 5'h00;
			step_pulse <= 1'b0;
			wg_cnt_reg <= 8'h00;
			wg_units_reg <= 4'h0;
			write_enable <= 1'b0;
		end else begin
			step_sync_reg <= {step_sync_reg[1:0], step_req};
			wr_sync_reg <= {wr_sync_reg[1:0], wr_req};
			if (step_sync_reg[1] == step_sync_reg[2]) step_lvl_reg <= step_sync_reg[2];
			if (wr_sync_reg[1] == wr_sync_reg[2]) wr_lvl_reg <= wr_sync_reg[2];
			// Half-millisecond enable, restarted at each pulse so every gap is whole units
			unit_tick_reg <= (unit_cnt_reg == STEP_UNIT_CYC - 1);
			unit_cnt_reg <= (unit_cnt_reg == STEP_UNIT_CYC - 1) ? 17'h00000 : unit_cnt_reg + 17'h00001;
			step_pulse <= 1'b0;
			if (step_lvl_reg && (step_gap_reg == 5'h00 || (step_gap_reg == 5'h01 && unit_tick_reg))) begin
				// Code 0 gives the longest 8 ms gap, code F the 0.5 ms one
				step_pulse <= 1'b1;
				step_gap_reg <= 5'h10 - {1'b0, step_interval};
				unit_cnt_reg <= 17'h00001; // Restart at one so the last tick meets the pulse edge
				unit_tick_reg <= 1'b0;
			end else if (step_gap_reg != 5'h00 && unit_tick_reg) begin
				step_gap_reg <= step_gap_reg - 5'h01;
			end
			// Pre-erase lead before write enable, in 1 us units
			if (!wr_lvl_reg) begin
				write_enable <= 1'b0;
				wg_cnt_reg <= 8'h00;
				wg_units_reg <= 4'h0;
			end else if (wg_units_reg >= write_gate_timing) begin
				write_enable <= 1'b1;
			end else if (wg_cnt_reg == `FRCS_WG_UNIT_CYC - 8'h01) begin
				wg_cnt_reg <= 8'h00;
				wg_units_reg <= wg_units_reg + 4'h1;
			end else begin
				wg_cnt_reg <= wg_cnt_reg + 8'h01;
			end
		end
	end
endmodule // frcs_seq

// file: verification/frcs_seq_monitor.sv
// Port checker for the read command sequencer.
// Assumes it is bound into each frcs_seq and sees that instance's ports.
`timescale 1ns/1ps
module frcs_seq_monitor #(
	parameter STEP_UNIT_CYC = 10,
	parameter FIFO_DEPTH = 8
) (
	input wire mclk,
	input wire rst,
	input wire cmd_ready,
	input wire busy,
	input wire res_valid,
	input wire res_rd,
	input wire [7:0] res_data,
	input wire step_pulse,
	input wire wr_req,
	input wire [3:0] write_gate_timing,
	input wire write_enable,
	input wire sys_valid,
	input wire sys_ready,
	input wire [7:0] sys_data,
	input wire [15:0] sector_length
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Shortest gap is one unit, never below eight cycles in any build we run
	a_step_gap: assert property (step_pulse |=> !step_pulse [*8])
		else $error("step pulses too close");
	a_ready_busy: assert property (!(cmd_ready && busy))
		else $error("command port open while busy");
	a_res_hold: assert property (res_valid && !res_rd |=> res_valid && $stable(res_data))
		else $error("result byte dropped before read");
	a_busy_end: assert property ($fell(busy) |-> $past(res_rd && res_valid))
		else $error("busy ended without a result read");
	a_sys_hold: assert property (sys_valid && !sys_ready |=> sys_valid && $stable(sys_data))
		else $error("system byte lost under stall");
	// Lead is a whole number of microseconds, so the first eight cycles stay low
	a_we_lead: assert property ($rose(wr_req) && write_gate_timing != 4'h0 |=>
		!write_enable [*8]) else $error("write enable without lead");
	// Three synchroniser stages, the level and the output register lie between
	a_we_drop: assert property (!wr_req [*6] |-> !write_enable)
		else $error("write enable outlives request");
	a_len_shape: assert property ($onehot0(sector_length) && sector_length[6:0] == 7'h00)
		else $error("sector length not 128 times a power of two");
endmodule // frcs_seq_monitor

bind frcs_seq frcs_seq_monitor #(.STEP_UNIT_CYC(STEP_UNIT_CYC), .FIFO_DEPTH(FIFO_DEPTH)) i_mon (
	.mclk(mclk), .rst(rst), .cmd_ready(cmd_ready), .busy(busy), .res_valid(res_valid),
	.res_rd(res_rd), .res_data(res_data), .step_pulse(step_pulse), .wr_req(wr_req),
	.write_gate_timing(write_gate_timing), .write_enable(write_enable), .sys_valid(sys_valid),
	.sys_ready(sys_ready), .sys_data(sys_data), .sector_length(sector_length));

// file: verification/frcs_drive_model.sv
// Drive-side model: streams 128-byte sectors with their address mark type.
// Assumes a byte is taken on an edge where sec_valid and sec_ready are high.
`timescale 1ns/1ps
module frcs_drive_model (
	input wire mclk,
	input wire sec_ready,
	output reg [7:0] sec_data,
	output reg sec_valid,
	output reg sec_start,
	output reg sec_deleted,
	output reg sec_last,
	output reg sec_error
);
	initial {sec_data, sec_valid, sec_start, sec_deleted, sec_last, sec_error} = 13'h0000;
	// Slow mode idles a cycle after each byte; idle data is inverted, never stale
	task play(input integer nsec, input [7:0] dels, input integer slow);
		integer s, i, k;
		repeat (4) @(posedge mclk);
		#1;
		for (s = 0; s < nsec; s = s + 1) begin
			sec_start = 1'b1;
			sec_deleted = dels[s];
			@(posedge mclk);
			#1 sec_start = 1'b0;
			for (i = 0; i < 128; i = i + 1) begin
				sec_data = {s[2:0], 5'h00} ^ i[7:0];
				sec_valid = 1'b1;
				sec_last = (i == 127);
				k = 0;
				while (sec_ready !== 1'b1 && k < 5000) begin
					@(posedge mclk);
					#1 k = k + 1;
				end
				@(posedge mclk);
				#1;
				if (slow || i == 127) begin
					{sec_valid, sec_last} = 2'h0;
					sec_data = ~sec_data;
					if (slow) @(posedge mclk);
					if (slow) #1;
				end
			end
		end
	endtask
endmodule // frcs_drive_model

// file: verification/frcs_seq_bench.sv
// Self-checking bench for the read command sequencer.
// Assumes the drive model on the sector side; the host side is driven here.
`timescale 1ns/1ps
module frcs_seq_bench;
	reg mclk = 1'b0, rst = 1'b1, cmd_wr = 1'b0, res_rd = 1'b0, step_req = 1'b0, wr_req = 1'b0;
	reg sys_ready = 1'b0;
	reg [7:0] cmd_data = 8'h00;
	reg [3:0] step_interval = 4'h0, write_gate_timing = 4'h0;
	wire cmd_ready, res_valid, busy, step_pulse, write_enable, sec_valid, sec_start, sec_deleted;
	wire sec_last, sec_error, sec_ready, sys_valid, density_select, head_select;
	wire [7:0] res_data, sec_data, sys_data, req_sector;
	wire [15:0] sector_length;
	wire [1:0] drive_select;
	wire [3:0] flags = {step_pulse, sys_valid, res_valid, cmd_ready};
	integer num_errors = 0, tests_run = 0, c, j;
	initial forever #5 mclk = ~mclk;
	frcs_seq #(.STEP_UNIT_CYC(10)) i_frcs_seq (.mclk(mclk), .rst(rst), .cmd_data(cmd_data),
		.cmd_wr(cmd_wr), .cmd_ready(cmd_ready), .res_data(res_data), .res_valid(res_valid),
		.res_rd(res_rd), .busy(busy), .step_interval(step_interval), .step_req(step_req),
		.write_gate_timing(write_gate_timing), .step_pulse(step_pulse), .wr_req(wr_req),
		.write_enable(write_enable), .sec_data(sec_data), .sec_valid(sec_valid),
		.sec_start(sec_start), .sec_deleted(sec_deleted), .sec_last(sec_last),
		.sec_error(sec_error), .sec_ready(sec_ready), .sys_data(sys_data), .sys_valid(sys_valid),
		.sys_ready(sys_ready), .req_sector(req_sector), .sector_length(sector_length),
		.density_select(density_select), .head_select(head_select), .drive_select(drive_select),
		.drive_two_side(1'b1), .drive_ready(1'b1));
	frcs_drive_model i_frcs_drive_model (.mclk(mclk), .sec_ready(sec_ready), .sec_data(sec_data),
		.sec_valid(sec_valid), .sec_start(sec_start), .sec_deleted(sec_deleted),
		.sec_last(sec_last), .sec_error(sec_error));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task tick;
		@(posedge mclk);
		#1;
	endtask
	task close_out;
		$display("num_errors %0d tests_run %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task cmp(input [15:0] got, input [15:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait on one handshake or step flag; running out ends the run
	task wait_hi(input integer which);
		c = 0;
		while (flags[which] !== 1'b1 && c < 5000) begin
			tick;
			c = c + 1;
		end
		if (c >= 5000) num_errors = num_errors + 1;
		if (c >= 5000) close_out;
	endtask
	// Bytes: opcode, drive, C, H, R, N, last sector; gap and limit fixed
	task send_cmd(input [55:0] b, input integer cnt);
		integer i;
		for (i = 0; i < cnt; i = i + 1) begin
			wait_hi(0);
			cmd_data = i < 7 ? b[55 - 8 * i -: 8] : (i == 7 ? 8'h1B : 8'hFF);
			cmd_wr = 1'b1;
			tick;
			cmd_wr = 1'b0;
			tick;
		end
	endtask
	task read_res(input [55:0] exp, input [6:0] care, input integer cnt);
		integer i;
		for (i = 0; i < cnt; i = i + 1) begin
			wait_hi(1);
			if (care[6 - i]) cmp(res_data, exp[55 - 8 * i -: 8]);
			res_rd = 1'b1;
			tick;
			res_rd = 1'b0;
			tick;
		end
		cmp({res_valid, busy}, 16'h0000);
	endtask
	// Host stalls while the FIFO fills, then drains and checks each kept sector
	task run_read(input [55:0] b, input integer nsec, input [7:0] dels, input [7:0] keep);
		integer s, i;
		send_cmd(b, 9);
		cmp(req_sector, {8'h00, b[23:16]});
		fork
			i_frcs_drive_model.play(nsec, dels, nsec & 1);
			begin
				repeat (40) tick;
				cmp(sec_ready, 16'h0000);
				sys_ready = 1'b1;
				for (s = 0; s < nsec; s = s + 1)
					for (i = 0; i < 128 * keep[s]; i = i + 1) begin
						wait_hi(2);
						cmp(sys_data, {8'h00, {s[2:0], 5'h00} ^ i[7:0]});
						tick;
					end
				tick;
				cmp(sys_valid, 16'h0000);
				sys_ready = 1'b0;
			end
		join
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reads;
		run_read(56'h46_00_02_00_01_00_02, 2, 8'h02, 8'h03);
		cmp({density_select, sector_length[14:0]}, 16'h8080);
		read_res(56'h40_80_40_03_00_01_00, 7'h7F, 7);
		run_read(56'h26_06_05_01_03_00_05, 3, 8'h02, 8'h05);
		cmp({density_select, head_select, drive_select}, 16'h0006);
		read_res(56'h46_80_00_06_01_01_00, 7'h6F, 7);
		run_read(56'h2C_01_07_00_01_00_03, 3, 8'h05, 8'h05);
		read_res(56'h41_80_00_08_00_01_00, 7'h6F, 7);
		run_read(56'hC6_00_09_00_02_00_02, 3, 8'h00, 8'h07);
		read_res(56'h40_80_00_0A_01_01_00, 7'h7F, 7);
	endtask
	task t_refuse;
		send_cmd(56'h47_00_00_00_00_00_00, 1);
		read_res(56'h80_00_00_00_00_00_00, 7'h40, 1);
		send_cmd(56'h46_00_01_00_01_08_01, 9);
		read_res(56'h40_00_00_00_00_00_00, 7'h40, 7);
	endtask
	task t_timing;
		for (j = 0; j < 2; j = j + 1) begin
			step_interval = j ? 4'h8 : 4'hF;
			step_req = 1'b1;
			wait_hi(3);
			wait_hi(3);
			while (step_pulse !== 1'b1 && c < 500) begin
				tick;
				c = c + 1;
			end
			tick;
			c = 1;
			while (step_pulse !== 1'b1 && c < 500) begin
				tick;
				c = c + 1;
			end
			cmp(c, (16 - step_interval) * 10);
			step_req = 1'b0;
			write_gate_timing = j ? 4'h5 : 4'h2;
			wr_req = 1'b1;
			c = 0;
			while (write_enable !== 1'b1 && c < 2000) begin
				tick;
				c = c + 1;
			end
			// Four synchroniser edges and the output register sit ahead of the lead
			cmp(c, 100 * write_gate_timing + 5);
			wr_req = 1'b0;
			repeat (300) tick;
			cmp(write_enable, 16'h0000);
		end
	endtask
	// Reset held five cycles, then every scenario in turn
	initial begin
		repeat (5) tick;
		rst = 1'b0;
		t_reads;
		t_refuse;
		t_timing;
		close_out;
	end
endmodule // frcs_seq_bench
